// >>> pkg/sch_pkg.sv
// Shared constants, types and helpers of the serial channel
package sch_pkg;
  localparam int DATA_W = 8;
  localparam int BAUD_W = 8;
  localparam logic [BAUD_W-1:0] BAUD_DIV_RST = 8'h07;
  // Least divisor software may program in UART mode off the bus clock
  localparam logic [BAUD_W-1:0] BAUD_DIV_MIN_UART = 8'h07;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] BITS_PLAIN = 4'h8;
  localparam logic [3:0] BITS_PARITY = 4'h9;
  localparam logic [3:0] BITS_SYNC = 4'h8;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [8:0] SHIFT_RST = 9'h1FF;

  typedef enum logic [1:0] {
    SCH_RX_IDLE = 2'b00,
    SCH_RX_START = 2'b01,
    SCH_RX_DATA = 2'b11,
    SCH_RX_STOP = 2'b10
  } sch_rx_state_t;

  typedef enum logic [1:0] {
    SCH_TX_IDLE = 2'b00,
    SCH_TX_START = 2'b01,
    SCH_TX_DATA = 2'b11,
    SCH_TX_STOP = 2'b10
  } sch_tx_state_t;

  // Parity bit that makes the frame even, or odd when odd is set
  function automatic logic sch_parity(input logic [DATA_W-1:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  // Data plus parity bits carried per UART character
  function automatic logic [3:0] sch_nbits(input logic par_en);
    return par_en ? BITS_PARITY : BITS_PLAIN;
  endfunction
endpackage

// >>> src/sch_baud.sv
// Baud-rate counter with deferred divisor update
`timescale 1ns/10ps
module sch_baud
  import sch_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic div_wr,
  input wire logic [BAUD_W-1:0] div_in,
  input wire logic idle,
  output logic tick
);
  logic [BAUD_W-1:0] div_reg, div_next, cnt_reg, cnt_next, pend_reg, pend_next;
  logic pend_v_reg, pend_v_next;

  always_comb begin
    div_next = div_reg;
    pend_next = pend_reg;
    pend_v_next = pend_v_reg;
    cnt_next = cnt_reg - 8'h01;
    if (cnt_reg == 8'h00) begin
      // Pending divisor only at the end of the running count
      if (pend_v_reg) begin
        div_next = pend_reg;
        cnt_next = pend_reg;
        pend_v_next = 1'b0;
      end else begin
        cnt_next = div_reg;
      end
    end
    if (div_wr && idle) begin
      // Channel idle: divisor and count restart at once
      div_next = div_in;
      cnt_next = div_in;
      pend_v_next = 1'b0;
    end else if (div_wr) begin
      pend_next = div_in;
      pend_v_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= BAUD_DIV_RST;
      cnt_reg <= BAUD_DIV_RST;
      pend_reg <= BAUD_DIV_RST;
      pend_v_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
      pend_v_reg <= pend_v_next;
    end
  end

  assign tick = (cnt_reg == 8'h00);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_baud_idle_load: assert property (div_wr && idle |=> div_reg == $past(div_in))
    else $error("idle divisor write not applied at once");
  chk_baud_defer: assert property (div_wr && !idle && cnt_reg != 8'h00
      |=> div_reg == $past(div_reg))
    else $error("busy divisor write applied mid count");
  chk_baud_apply: assert property (pend_v_reg && cnt_reg == 8'h00 && !div_wr
      |=> div_reg == $past(pend_reg))
    else $error("pending divisor not applied at count end");
endmodule

// >>> src/sch_uart_rx.sv
// UART receive shifter with 16x oversampling
`timescale 1ns/10ps
module sch_uart_rx
  import sch_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic tick,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic rxd,
  output logic done,
  output logic [DATA_W-1:0] data,
  output logic par_err,
  output logic frm_err,
  output logic busy
);
  sch_rx_state_t st_reg, st_next;
  logic [3:0] ovs_reg, ovs_next, bit_reg, bit_next;
  logic [8:0] sh_reg, sh_next;
  logic done_next, perr_next, ferr_next, perr_reg, ferr_reg;
  logic [DATA_W-1:0] dat_w;

  assign dat_w = par_en ? sh_reg[7:0] : sh_reg[8:1];

  always_comb begin
    st_next = st_reg;
    ovs_next = ovs_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    done_next = 1'b0;
    perr_next = perr_reg;
    ferr_next = ferr_reg;
    if (!en) begin
      st_next = SCH_RX_IDLE;
    end else if (tick) begin
      ovs_next = ovs_reg + 4'h1;
      unique case (st_reg)
        SCH_RX_IDLE: begin
          ovs_next = 4'h0;
          if (!rxd) st_next = SCH_RX_START;
        end
        SCH_RX_START: begin
          if (ovs_reg == OVS_MID) begin
            ovs_next = 4'h0;
            bit_next = 4'h0;
            // A glitch shorter than half a bit is not a start
            st_next = rxd ? SCH_RX_IDLE : SCH_RX_DATA;
          end
        end
        SCH_RX_DATA: begin
          if (ovs_reg == OVS_LAST) begin
            sh_next = {rxd, sh_reg[8:1]};
            bit_next = bit_reg + 4'h1;
            if (bit_reg == sch_nbits(par_en) - 4'h1) st_next = SCH_RX_STOP;
          end
        end
        SCH_RX_STOP: begin
          if (ovs_reg == OVS_LAST) begin
            done_next = 1'b1;
            ferr_next = !rxd;
            perr_next = par_en && (sh_reg[8] != sch_parity(sh_reg[7:0], par_odd));
            st_next = SCH_RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= SCH_RX_IDLE;
      ovs_reg <= 4'h0;
      bit_reg <= 4'h0;
      sh_reg <= SHIFT_RST;
      done <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ovs_reg <= ovs_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      done <= done_next;
      perr_reg <= perr_next;
      ferr_reg <= ferr_next;
    end
  end

  assign data = dat_w;
  assign par_err = perr_reg;
  assign frm_err = ferr_reg;
  assign busy = (st_reg != SCH_RX_IDLE);
endmodule

// >>> src/sch_channel.sv
// Serial channel: transmitter, receive buffer, status flags and DMA requests
// How it works
// - Character completing while buffer unread sets overrun, is dropped, buffer kept.
// - After overrun, shifting continues, nothing stored; receive status reads 1.
// - Overrun clears only by software dropping receive enable, then setting it again.
// - Transmit DMA request whenever transmit buffer empty and transmit enabled.
// - Receive DMA request raised when receive-finished becomes set.
// - Receive DMA request held off while overrun is present.
// - Busy-channel divisor write applies after the current count completes.
// - Divisor write with both directions disabled applies immediately.
// - UART status: receive status, finished, error sum, overrun, parity, framing.
// - Without overrun, low-byte read or receive disable clears finished and errors.
// - With overrun, only receive disable clears finished and errors.
// - Synchronous receive is clocked by the transmitter; dummy data goes out.
`timescale 1ns/10ps
module sch_channel
  import sch_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mode_uart,
  input wire logic tx_en,
  input wire logic rx_en,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic baud_wr,
  input wire logic [BAUD_W-1:0] baud_div,
  input wire logic tx_wr,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic rx_rd_lo,
  input wire logic rxd,
  output logic txd,
  output logic sclk_out,
  output logic [DATA_W-1:0] rx_data,
  output logic tx_empty,
  output logic rx_busy,
  output logic rx_done,
  output logic err_sum,
  output logic err_ovr,
  output logic err_par,
  output logic err_frm,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  logic tick, u_done, u_perr, u_ferr, u_busy, idle_w;
  logic [DATA_W-1:0] u_data;

  // Software keeps mode, divisor and source still unless both enables are clear
  assign idle_w = !tx_en && !rx_en;

  sch_baud u_baud (
    .clk(clk),
    .rst(rst),
    .div_wr(baud_wr),
    .div_in(baud_div),
    .idle(idle_w),
    .tick(tick)
  );

  sch_uart_rx u_rx (
    .clk(clk),
    .rst(rst),
    .en(rx_en && mode_uart),
    .tick(tick),
    .par_en(par_en),
    .par_odd(par_odd),
    .rxd(rxd),
    .done(u_done),
    .data(u_data),
    .par_err(u_perr),
    .frm_err(u_ferr),
    .busy(u_busy)
  );

  // Transmit side
  sch_tx_state_t tx_st_reg, tx_st_next;
  logic [3:0] ovs_reg, ovs_next, bit_reg, bit_next;
  logic [8:0] tsh_reg, tsh_next;
  logic [DATA_W-1:0] tbuf_reg, tbuf_next, ssh_reg, ssh_next;
  logic tx_empty_next, txd_next, sclk_next, syn_done_reg, syn_done_next;

  always_comb begin
    tx_st_next = tx_st_reg;
    ovs_next = ovs_reg;
    bit_next = bit_reg;
    tsh_next = tsh_reg;
    tbuf_next = tbuf_reg;
    ssh_next = ssh_reg;
    tx_empty_next = tx_empty;
    txd_next = txd;
    sclk_next = sclk_out;
    syn_done_next = 1'b0;
    if (!tx_en) begin
      tx_st_next = SCH_TX_IDLE;
      txd_next = 1'b1;
      sclk_next = 1'b1;
    end else if (tick) begin
      ovs_next = ovs_reg + 4'h1;
      unique case (tx_st_reg)
        SCH_TX_IDLE: begin
          ovs_next = 4'h0;
          bit_next = 4'h0;
          if (!tx_empty) begin
            tsh_next = {sch_parity(tbuf_reg, par_odd), tbuf_reg};
            tx_empty_next = 1'b1;
            if (mode_uart) begin
              txd_next = 1'b0;
              tx_st_next = SCH_TX_START;
            end else begin
              tx_st_next = SCH_TX_DATA;
            end
          end
        end
        SCH_TX_START: begin
          if (ovs_reg == OVS_LAST) begin
            txd_next = tsh_reg[0];
            tsh_next = {1'b1, tsh_reg[8:1]};
            tx_st_next = SCH_TX_DATA;
          end
        end
        SCH_TX_DATA: begin
          if (!mode_uart) begin
            // Receive is clocked by this shifter in synchronous mode
            if (!ovs_reg[0]) begin
              sclk_next = 1'b0;
              txd_next = tsh_reg[0];
              tsh_next = {1'b1, tsh_reg[8:1]};
            end else begin
              sclk_next = 1'b1;
              ssh_next = {rxd, ssh_reg[7:1]};
              bit_next = bit_reg + 4'h1;
              if (bit_reg == BITS_SYNC - 4'h1) begin
                syn_done_next = 1'b1;
                tx_st_next = SCH_TX_IDLE;
              end
            end
          end else if (ovs_reg == OVS_LAST) begin
            bit_next = bit_reg + 4'h1;
            if (bit_reg == sch_nbits(par_en) - 4'h1) begin
              txd_next = 1'b1;
              tx_st_next = SCH_TX_STOP;
            end else begin
              txd_next = tsh_reg[0];
              tsh_next = {1'b1, tsh_reg[8:1]};
            end
          end
        end
        SCH_TX_STOP: begin
          if (ovs_reg == OVS_LAST) tx_st_next = SCH_TX_IDLE;
        end
      endcase
    end
    // Write after the load so a same-cycle refill is not lost
    if (tx_wr) begin
      tbuf_next = tx_data;
      tx_empty_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_reg <= SCH_TX_IDLE;
      ovs_reg <= 4'h0;
      bit_reg <= 4'h0;
      tsh_reg <= SHIFT_RST;
      tbuf_reg <= DATA_RST;
      ssh_reg <= DATA_RST;
      tx_empty <= 1'b1;
      txd <= 1'b1;
      sclk_out <= 1'b1;
      syn_done_reg <= 1'b0;
    end else begin
      tx_st_reg <= tx_st_next;
      ovs_reg <= ovs_next;
      bit_reg <= bit_next;
      tsh_reg <= tsh_next;
      tbuf_reg <= tbuf_next;
      ssh_reg <= ssh_next;
      tx_empty <= tx_empty_next;
      txd <= txd_next;
      sclk_out <= sclk_next;
      syn_done_reg <= syn_done_next;
    end
  end

  // Receive buffer and status flags
  logic char_ev, ev_perr, ev_ferr, rd_clr;
  logic [DATA_W-1:0] ev_data, rx_data_next;
  logic rx_done_next, ovr_next, par_next, frm_next;
  logic rx_busy_next, err_sum_next, dma_tx_next, dma_rx_next;

  assign char_ev = mode_uart ? u_done : syn_done_reg;
  assign ev_data = mode_uart ? u_data : ssh_reg;
  assign ev_perr = mode_uart && u_perr;
  assign ev_ferr = mode_uart && u_ferr;
  // A read clears nothing once overrun is flagged
  assign rd_clr = rx_rd_lo && !err_ovr;

  always_comb begin
    rx_data_next = rx_data;
    rx_done_next = rx_done;
    ovr_next = err_ovr;
    par_next = err_par;
    frm_next = err_frm;
    if (!rx_en) begin
      // Dropping receive enable is the one clear that always works
      rx_done_next = 1'b0;
      ovr_next = 1'b0;
      par_next = 1'b0;
      frm_next = 1'b0;
    end else begin
      if (rd_clr) begin
        rx_done_next = 1'b0;
        par_next = 1'b0;
        frm_next = 1'b0;
      end
      if (char_ev) begin
        if (err_ovr) begin
          // Keep receiving but store nothing
        end else if (rx_done && !rd_clr) begin
          ovr_next = 1'b1;
        end else begin
          // New character beats a same-cycle read clear
          rx_data_next = ev_data;
          rx_done_next = 1'b1;
          par_next = ev_perr;
          frm_next = ev_ferr;
        end
      end
    end
    // Status seen by software in UART and synchronous mode, and DMA requests
    rx_busy_next = ovr_next || (rx_en && (mode_uart ? u_busy : tx_st_next == SCH_TX_DATA));
    err_sum_next = ovr_next || par_next || frm_next;
    dma_tx_next = tx_empty_next && tx_en;
    dma_rx_next = rx_done_next && !ovr_next;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data <= DATA_RST;
      rx_done <= 1'b0;
      err_ovr <= 1'b0;
      err_par <= 1'b0;
      err_frm <= 1'b0;
      rx_busy <= 1'b0;
      err_sum <= 1'b0;
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
    end else begin
      rx_data <= rx_data_next;
      rx_done <= rx_done_next;
      err_ovr <= ovr_next;
      err_par <= par_next;
      err_frm <= frm_next;
      rx_busy <= rx_busy_next;
      err_sum <= err_sum_next;
      dma_tx_req <= dma_tx_next;
      dma_rx_req <= dma_rx_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_full_hit;
    rx_en && char_ev && rx_done && !err_ovr && !rx_rd_lo;
  endsequence

  chk_ovr_drop_char: assert property (s_full_hit |=> err_ovr && $stable(rx_data))
    else $error("overrun not flagged or buffer overwritten");
  chk_ovr_no_store: assert property (err_ovr && rx_en |=> $stable(rx_data) && rx_busy)
    else $error("buffer changed or status low during overrun");
  chk_ovr_only_rxen: assert property (err_ovr && rx_en |=> err_ovr)
    else $error("overrun cleared while receive enabled");
  chk_dma_tx_req: assert property (dma_tx_req == (tx_empty && $past(tx_en)))
    else $error("transmit dma request wrong");
  chk_dma_rx_req: assert property (rx_done && !err_ovr |-> dma_rx_req)
    else $error("receive dma request missing");
  chk_dma_rx_ovr: assert property (err_ovr |-> !dma_rx_req)
    else $error("receive dma request during overrun");
  chk_rd_clears: assert property (rx_en && rx_rd_lo && !err_ovr && !char_ev
      |=> !rx_done && !err_par && !err_frm)
    else $error("read did not clear receive flags");
  chk_rd_keeps: assert property (err_ovr && rx_en ##1 rx_en |-> rx_done)
    else $error("receive finished lost during overrun");
  chk_rxen_clears: assert property (!rx_en |=> !rx_done && !err_ovr && !err_sum)
    else $error("receive disable did not clear flags");
  chk_err_sum_or: assert property (err_sum == (err_ovr || err_par || err_frm))
    else $error("error sum disagrees with error bits");
endmodule

// >>> testbench/sch_peer.sv
// Remote serial peer: UART sender and receiver, clocked synchronous slave
`timescale 1ns/10ps
module sch_peer
  import sch_pkg::*;
(
  input wire logic clk,
  input wire logic uart,
  input wire logic [15:0] bit_clks,
  input wire logic txd,
  input wire logic sclk_out,
  output logic rxd,
  output logic got,
  output logic [DATA_W-1:0] got_byte,
  output logic [DATA_W-1:0] cap
);
  logic [DATA_W-1:0] b;
  logic [DATA_W-1:0] sync_byte;
  int sidx = 8;
  int i;

  initial rxd = 1'b1;
  initial got = 1'b0;

  task automatic drive_bit(input logic v);
    rxd <= v;
    repeat (bit_clks) @(posedge clk);
  endtask

  // Bit time follows bit_clks, which the bench keeps at or above divisor 7
  task automatic send(input logic [DATA_W-1:0] d, input logic par, input logic odd,
                      input logic bad_par, input logic bad_stop);
    @(posedge clk);
    drive_bit(1'b0);
    for (int k = 0; k < DATA_W; k++) begin
      drive_bit(d[k]);
    end
    if (par) begin
      drive_bit((^d) ^ odd ^ bad_par);
    end
    drive_bit(~bad_stop);
    // Spare idle bit so the receiver is settled when the task returns
    drive_bit(1'b1);
  endtask

  task automatic arm_sync(input logic [DATA_W-1:0] d);
    sync_byte = d;
    sidx = 0;
  endtask

  always begin
    @(negedge txd iff uart);
    repeat (bit_clks / 2) @(posedge clk);
    if (txd === 1'b0) begin
      for (i = 0; i < DATA_W; i++) begin
        repeat (bit_clks) @(posedge clk);
        b[i] = txd;
      end
      repeat (bit_clks) @(posedge clk);
      got_byte <= b;
      got <= 1'b1;
      @(posedge clk);
      got <= 1'b0;
    end
  end

  // Synchronous data follows the shift clock the device makes
  always @(negedge sclk_out) begin
    if (!uart && sidx < DATA_W) begin
      rxd <= sync_byte[sidx];
      sidx <= sidx + 1;
    end else if (!uart) begin
      // Past the last bit: line toggles on each falling edge, no stale level
      rxd <= ~rxd;
    end
  end

  always @(posedge sclk_out) begin
    if (!uart) begin
      cap <= {txd, cap[DATA_W-1:1]};
    end
  end
endmodule

// >>> testbench/tb.sv
// Self-checking bench of the serial channel status, error and request logic
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb
  import sch_pkg::*;
;
  logic clk, rst, mode_uart, tx_en, rx_en, par_en, par_odd, baud_wr, tx_wr, rx_rd_lo;
  logic [BAUD_W-1:0] baud_div;
  logic [DATA_W-1:0] tx_data, rx_data, got_byte, cap, d0, d1, d2, e;
  logic rxd, txd, sclk_out, tx_empty, rx_busy, rx_done, err_sum, err_ovr, err_par, err_frm;
  logic dma_tx_req, dma_rx_req, got, puart, prev_done;
  logic [15:0] bit_clks;
  logic [DATA_W-1:0] exp_q[$];
  int n_fail = 0;
  int comparisons = 0;
  int seed = 2857;

  sch_channel i_sch_channel (.clk(clk), .rst(rst), .mode_uart(mode_uart), .tx_en(tx_en),
    .rx_en(rx_en), .par_en(par_en), .par_odd(par_odd), .baud_wr(baud_wr),
    .baud_div(baud_div), .tx_wr(tx_wr), .tx_data(tx_data), .rx_rd_lo(rx_rd_lo), .rxd(rxd),
    .txd(txd), .sclk_out(sclk_out), .rx_data(rx_data), .tx_empty(tx_empty),
    .rx_busy(rx_busy), .rx_done(rx_done), .err_sum(err_sum), .err_ovr(err_ovr),
    .err_par(err_par), .err_frm(err_frm), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));

  sch_peer i_sch_peer (.clk(clk), .uart(puart), .bit_clks(bit_clks), .txd(txd),
    .sclk_out(sclk_out), .rxd(rxd), .got(got), .got_byte(got_byte), .cap(cap));

  always #50 clk = ~clk;

  task automatic tally_and_finish();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    step();
    s = 1'b1;
    step();
    s = 1'b0;
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 5000 && exp_q.size() > 0; i++) @(posedge clk);
    #1;
    if (exp_q.size() > 0) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  // Results are taken off the queue in arrival order
  always @(posedge clk) begin
    if ((rx_done === 1'b1 && prev_done !== 1'b1) || got === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("FAIL t=%0t got=%h exp=%h", $time, rx_data, 8'h00);
      end else begin
        e = exp_q.pop_front();
        if (got === 1'b1) `CHK(got_byte, e)
        else `CHK(rx_data, e)
      end
    end
    prev_done <= rx_done;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    clk = 0; rst = 1; mode_uart = 1; tx_en = 0; rx_en = 0; par_en = 0; par_odd = 0;
    baud_wr = 0; baud_div = 8'h07; tx_wr = 0; tx_data = 8'h00; rx_rd_lo = 0;
    bit_clks = 16'd128; puart = 1; prev_done = 0;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    // Reset values of all outputs except rx_data, requests included, checked once before any traffic starts
    `CHK({txd, sclk_out, tx_empty, rx_busy, rx_done, err_sum, err_ovr, err_par, err_frm,
      dma_tx_req, dma_rx_req}, 11'h700)
    // Transmit: buffer written before enabling, then refilled mid-character
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    exp_q.push_back(d0);
    exp_q.push_back(d1);
    step(); tx_data = d0; tx_wr = 1;
    step(); tx_wr = 0;
    `CHK({tx_empty, dma_tx_req}, 2'h0)
    step(); tx_en = 1;
    repeat (40) step();
    `CHK({tx_empty, dma_tx_req}, 2'h3)
    step(); tx_data = d1; tx_wr = 1;
    step(); tx_wr = 0;
    `CHK({tx_empty, dma_tx_req}, 2'h0)
    drain();
    // Plain reception, cleared by a low-byte read
    step(); tx_en = 0; rx_en = 1;
    d0 = 8'($random(seed));
    exp_q.push_back(d0);
    i_sch_peer.send(d0, 0, 0, 0, 0);
    drain();
    `CHK({rx_done, dma_rx_req, err_sum, rx_busy}, 4'hC)
    pulse(rx_rd_lo);
    `CHK({rx_done, dma_rx_req}, 2'h0)
    // Both parities, with and without a bad parity bit
    for (int k = 0; k < 4; k++) begin
      step(); rx_en = 0; par_en = 1; par_odd = k[0];
      step(); rx_en = 1;
      d0 = 8'($random(seed));
      exp_q.push_back(d0);
      i_sch_peer.send(d0, 1, k[0], k[1], 0);
      drain();
      `CHK({err_par, err_sum, err_frm}, {k[1], k[1], 1'b0})
      pulse(rx_rd_lo);
      `CHK({rx_done, err_par, err_sum}, 3'h0)
    end
    step(); rx_en = 0; par_en = 0;
    step(); rx_en = 1;
    d0 = 8'($random(seed));
    exp_q.push_back(d0);
    i_sch_peer.send(d0, 0, 0, 0, 1);
    drain();
    `CHK({err_frm, err_sum}, 2'h3)
    step(); rx_en = 0;
    step();
    `CHK({rx_done, err_frm, err_sum}, 3'h0)
    rx_en = 1;
    // Overrun: second character lost, read does not clear, disable does
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    exp_q.push_back(d0);
    i_sch_peer.send(d0, 0, 0, 0, 0);
    i_sch_peer.send(d1, 0, 0, 0, 0);
    drain();
    `CHK(rx_data, d0)
    `CHK({rx_done, err_ovr, err_sum, rx_busy, dma_rx_req}, 5'h1E)
    pulse(rx_rd_lo);
    `CHK({rx_done, err_ovr}, 2'h3)
    i_sch_peer.send(d2, 0, 0, 0, 0);
    `CHK(rx_data, d0)
    step(); rx_en = 0;
    step();
    `CHK({rx_done, err_ovr, err_sum, rx_busy}, 4'h0)
    rx_en = 1;
    d0 = 8'($random(seed));
    exp_q.push_back(d0);
    i_sch_peer.send(d0, 0, 0, 0, 0);
    drain();
    // Divisor written while idle applies at once
    step(); rx_en = 0; baud_div = 8'h09; baud_wr = 1;
    step(); baud_wr = 0; bit_clks = 16'd160; rx_en = 1;
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    exp_q.push_back(d0);
    i_sch_peer.send(d0, 0, 0, 0, 0);
    drain();
    pulse(rx_rd_lo);
    exp_q.push_back(d1);
    step(); tx_data = d1; tx_wr = 1; tx_en = 1;
    step(); tx_wr = 0;
    drain();
    // Synchronous mode: dummy transmit clocks the reception
    // Two ticks a bit: divisor 9, then 11, stays far below 2 Mbps
    step(); tx_en = 0; rx_en = 0; mode_uart = 0; puart = 0;
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    i_sch_peer.arm_sync(d0);
    exp_q.push_back(d0);
    step(); rx_en = 1; tx_data = d1; tx_wr = 1; tx_en = 1;
    step(); tx_wr = 0;
    // Busy divisor write held two edges, so at least one falls mid count
    step(); baud_div = 8'h0B; baud_wr = 1;
    repeat (2) step();
    baud_wr = 0;
    drain();
    `CHK(cap, d1)
    step(); tx_en = 0; rx_en = 0;
    step();
    tally_and_finish();
  end
endmodule
